// [rtl/tdlt_consts.svh]
// constants of the line trigger and scan direction front end
`ifndef TDLT_CONSTS_SVH
`define TDLT_CONSTS_SVH
`define TDLT_ADDR_CTRL     12'h000
`define TDLT_ADDR_DIVISOR  12'h004
`define TDLT_ADDR_SHUTTER  12'h008
`define TDLT_ADDR_STATUS   12'h00C
`define TDLT_ADDR_COUNT    12'h010
`define TDLT_CTRL_ONLINE   0
`define TDLT_CTRL_QUAD     1
`define TDLT_CTRL_TERM     2
`define TDLT_CTRL_RESET    32'h0000_0000
`define TDLT_DIVISOR_RESET 16'h0001
`define TDLT_SHUTTER_RESET 20'h003E8
`define TDLT_MULT          256
`define TDLT_MULT_SHIFT    8
`define TDLT_SHUTTER_NS_PER_CYC 10
`endif

// [rtl/tdlt_pkg.sv]
// types of the line trigger and scan direction front end
`default_nettype none
package tdlt_pkg;
   typedef struct packed {
      logic        online;
      logic        quad;
      logic        term;
      logic [15:0] divisor;
      logic [19:0] shutter;
   } tdlt_cfg_t;
   typedef enum logic [1:0] {TDLT_IDLE, TDLT_EXPOSE} tdlt_state_t;
endpackage : tdlt_pkg
`default_nettype wire

// [rtl/tdlt_sync.sv]
// two flip-flop synchroniser for one pin level
`default_nettype none
module tdlt_sync (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic pin_in,
   output logic      level_out
);
   logic meta_reg;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta_reg  <= 1'b0;
         level_out <= 1'b0;
      end else begin
         meta_reg  <= pin_in;
         level_out <= meta_reg;
      end
   end
endmodule : tdlt_sync
`default_nettype wire

// [rtl/tdlt_top.sv]
// line trigger, scan direction and line exposure sequencing with AHB-Lite registers
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`default_nettype none
`include "tdlt_consts.svh"
module tdlt_top import tdlt_pkg::*; (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        line_ttl_in,
   input  wire logic        line_lvds_in,
   input  wire logic        aux_ttl_in,
   input  wire logic        aux_lvds_in,
   input  wire logic        frame_ttl_in,
   output logic             lvds_term_en,
   output logic             expose_line0,
   output logic             expose_line1,
   output logic             shift_fwd,
   output logic             frame_start
);
   tdlt_cfg_t   cfg_reg;
   tdlt_state_t state_reg;
   logic        lt_s, lv_s, at_s, av_s, fr_s;
   logic        pa_reg, pb_reg, fr_reg, dir_reg, row_sel_reg;
   logic [23:0] acc_reg;
   logic [19:0] exp_cnt_reg, int_cnt_reg;
   logic [31:0] line_count_reg;
   logic        wr_pend_reg;
   logic [11:0] wr_addr_reg;
   logic [31:0] rd_word;
   logic        step, edge_single, trig_ext, trig_int, trig, dir_now;
   logic        pa, pb, conv_tick;
   logic [23:0] acc_sum;
   wire  [23:0] div_wide = {8'h00, cfg_reg.divisor};

   // pins are asynchronous, so every one passes two flip-flops
   tdlt_sync u_lt (.hclk(hclk), .hresetn(hresetn), .pin_in(line_ttl_in), .level_out(lt_s));
   tdlt_sync u_lv (.hclk(hclk), .hresetn(hresetn), .pin_in(line_lvds_in), .level_out(lv_s));
   tdlt_sync u_at (.hclk(hclk), .hresetn(hresetn), .pin_in(aux_ttl_in), .level_out(at_s));
   tdlt_sync u_av (.hclk(hclk), .hresetn(hresetn), .pin_in(aux_lvds_in), .level_out(av_s));
   tdlt_sync u_fr (.hclk(hclk), .hresetn(hresetn), .pin_in(frame_ttl_in), .level_out(fr_s));

   // receiver choice follows the termination setting, except the single-phase direction, which always reads aux TTL
   assign pa = cfg_reg.term ? lv_s : lt_s;
   assign pb = cfg_reg.term ? av_s : at_s;

   // a legal quadrature step changes exactly one phase
   assign step     = (pa ^ pa_reg) ^ (pb ^ pb_reg);
   assign edge_single = pa && !pa_reg;

   // quadrature: direction from which phase moved relative to the other
   logic quad_fwd;
   assign quad_fwd = (pa != pa_reg) ? (pa != pb) : (pb == pa);
   wire  ext_pulse = cfg_reg.quad ? step : edge_single;
   // a reversing encoder must not expose its first row in the stale line order
   assign dir_now = (cfg_reg.quad && step) ? quad_fwd : dir_reg;

   // frequency converter: each input event adds 256, a line fires per divisor
   assign acc_sum   = acc_reg + (ext_pulse ? 24'(`TDLT_MULT) : 24'h000000);
   assign conv_tick = acc_sum >= div_wide;
   assign trig_ext  = cfg_reg.online && conv_tick;
   assign trig_int  = !cfg_reg.online && (int_cnt_reg == 20'h00000);
   assign trig      = (trig_ext || trig_int) && (state_reg == TDLT_IDLE);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pa_reg  <= 1'b0;
         pb_reg  <= 1'b0;
         fr_reg  <= 1'b0;
         dir_reg <= 1'b0;
         acc_reg <= 24'h000000;
      end else begin
         pa_reg <= pa;
         pb_reg <= pb;
         fr_reg <= fr_s;
         // more than one line may be owed; remainder stays, burst drains one a cycle
         acc_reg <= conv_tick ? acc_sum - div_wide : acc_sum;
         if (!cfg_reg.quad)
            dir_reg <= at_s;
         else if (step)
            dir_reg <= quad_fwd;
      end
   end

   // exposure timing: a line lasts the shutter time; triggers in it are dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg      <= TDLT_IDLE;
         exp_cnt_reg    <= 20'h00000;
         int_cnt_reg    <= 20'h00000;
         row_sel_reg    <= 1'b0;
         line_count_reg <= 32'h0000_0000;
      end else begin
         int_cnt_reg <= (int_cnt_reg == 20'h00000) ? cfg_reg.shutter : int_cnt_reg - 20'h00001;
         case (state_reg)
            TDLT_IDLE: begin
               if (trig) begin
                  state_reg      <= TDLT_EXPOSE;
                  exp_cnt_reg    <= cfg_reg.shutter;
                  row_sel_reg    <= dir_now;
                  line_count_reg <= line_count_reg + 32'h0000_0001;
               end
            end
            TDLT_EXPOSE: begin
               if (exp_cnt_reg <= 20'h00001)
                  state_reg <= TDLT_IDLE;
               else
                  exp_cnt_reg <= exp_cnt_reg - 20'h00001;
            end
            default: state_reg <= TDLT_IDLE;
         endcase
      end
   end

   // outputs: the first line of the row is chosen by direction
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         expose_line0 <= 1'b0;
         expose_line1 <= 1'b0;
         shift_fwd    <= 1'b0;
         frame_start  <= 1'b0;
         lvds_term_en <= 1'b0;
      end else begin
         expose_line0 <= trig && dir_now;
         expose_line1 <= trig && !dir_now;
         shift_fwd    <= dir_reg;
         frame_start  <= fr_s && !fr_reg;
         lvds_term_en <= cfg_reg.term;
      end
   end

   // AHB-Lite slave: zero wait states, writes land in the data phase
   wire addr_ok = hsel && htrans[1] && hready;
   always_comb begin
      rd_word = 32'h0000_0000;
      case (haddr)
         `TDLT_ADDR_CTRL:    rd_word = {29'h0, cfg_reg.term, cfg_reg.quad, cfg_reg.online};
         `TDLT_ADDR_DIVISOR: rd_word = {16'h0000, cfg_reg.divisor};
         `TDLT_ADDR_SHUTTER: rd_word = {12'h000, cfg_reg.shutter};
         `TDLT_ADDR_STATUS:  rd_word = {29'h0, row_sel_reg, state_reg == TDLT_EXPOSE, dir_reg};
         `TDLT_ADDR_COUNT:   rd_word = line_count_reg;
         default:            rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 12'h000;
         hrdata      <= 32'h0000_0000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
         cfg_reg     <= '{online: 1'b0, quad: 1'b0, term: 1'b0,
                          divisor: `TDLT_DIVISOR_RESET, shutter: `TDLT_SHUTTER_RESET};
      end else begin
         wr_pend_reg <= addr_ok && hwrite;
         wr_addr_reg <= haddr;
         if (addr_ok && !hwrite)
            hrdata <= rd_word;
         if (wr_pend_reg) begin
            case (wr_addr_reg)
               `TDLT_ADDR_CTRL: begin
                  cfg_reg.online <= hwdata[`TDLT_CTRL_ONLINE];
                  cfg_reg.quad   <= hwdata[`TDLT_CTRL_QUAD];
                  cfg_reg.term   <= hwdata[`TDLT_CTRL_TERM];
               end
               // divisor of zero is outside 1..65535, kept at one
               `TDLT_ADDR_DIVISOR: cfg_reg.divisor <= (hwdata[15:0] == 16'h0000) ?
                                                      16'h0001 : hwdata[15:0];
               `TDLT_ADDR_SHUTTER: cfg_reg.shutter <= hwdata[19:0];
               default: ;
            endcase
         end
      end
   end

   a_early_trig_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
      (state_reg == TDLT_EXPOSE) |-> !(expose_line0 || expose_line1) || $past(trig))
      else $error("trigger accepted during exposure");
   a_line_select: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(trig && !(cfg_reg.quad && step)) |-> (expose_line0 == $past(dir_reg)))
      else $error("wrong first sensor line");
   a_quad_line: assert property (@(posedge hclk) disable iff (!hresetn)
      $past(trig && cfg_reg.quad && step) |-> (expose_line0 == $past(quad_fwd)))
      else $error("quadrature step exposed in wrong first line");
   a_single_dir: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_reg.quad && $stable(cfg_reg.quad) |=> ##1 (shift_fwd == $past(at_s, 2)))
      else $error("single phase direction not followed");
   a_illegal_step: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_reg.quad && (pa != pa_reg) && (pb != pb_reg) |=> $stable(dir_reg))
      else $error("double phase change moved direction");
   a_quad_fwd: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_reg.quad && step && quad_fwd |=> dir_reg)
      else $error("A leading B did not select forward");
   a_term_out: assert property (@(posedge hclk) disable iff (!hresetn)
      ##1 lvds_term_en == $past(cfg_reg.term))
      else $error("termination output does not follow setting");
   a_div_range: assert property (@(posedge hclk) disable iff (!hresetn)
      cfg_reg.divisor != 16'h0000)
      else $error("divisor left legal range");
   a_offline_ext: assert property (@(posedge hclk) disable iff (!hresetn)
      !cfg_reg.online |-> !trig_ext)
      else $error("external trigger used offline");
endmodule : tdlt_top
`default_nettype wire

// [sim/tdlt_enc_model.sv]
// encoder, line trigger and frame trigger source driving the camera pins
`default_nettype none
module tdlt_enc_model (
   input  wire logic hclk,
   input  wire logic term,
   input  wire logic quad,
   output logic      line_ttl_in,
   output logic      line_lvds_in,
   output logic      aux_ttl_in,
   output logic      aux_lvds_in,
   output logic      frame_ttl_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic a = 1'b0;
   logic b = 1'b0;
   logic f = 1'b0;
   // the receiver not in use sees the inverse, except aux TTL with term set in single-phase mode, so a wrong pick shows up
   assign line_ttl_in  = term ? ~a : a;
   assign line_lvds_in = term ? a : ~a;
   assign aux_ttl_in   = (term && quad) ? ~b : b;
   assign aux_lvds_in  = term ? b : ~b;
   assign frame_ttl_in = f;
   task automatic step(input logic fwd, input logic both);
      @(posedge hclk);
      if (both) begin
         a <= ~a;
         b <= ~b;
      end else if (fwd == (a == b)) a <= ~a;
      else b <= ~b;
      repeat (15) @(posedge hclk);
   endtask : step
   task automatic pulse(input int gap);
      @(posedge hclk) a <= 1'b0;
      @(posedge hclk) a <= 1'b1;
      repeat (3) @(posedge hclk);
      a <= 1'b0;
      repeat (gap) @(posedge hclk);
   endtask : pulse
   task automatic set_dir(input logic v);
      @(posedge hclk) b <= v;
      repeat (4) @(posedge hclk);
   endtask : set_dir
   task automatic frame_pulse;
      @(posedge hclk) f <= 1'b1;
      repeat (3) @(posedge hclk);
      f <= 1'b0;
      repeat (8) @(posedge hclk);
   endtask : frame_pulse
endmodule : tdlt_enc_model
`default_nettype wire

// [sim/tdi_line_trigger_direction_tb_top.sv]
// self-checking bench of the line trigger and scan direction front end
`default_nettype none
`include "tdlt_consts.svh"
module tdi_line_trigger_direction_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        hclk    = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel    = 1'b0;
   logic [2:0]  hsize   = 3'h0;
   logic [11:0] haddr   = 12'h000;
   logic [1:0]  htrans  = 2'h0;
   logic        hwrite  = 1'b0;
   logic [31:0] hwdata  = 32'h0;
   logic        quad_m  = 1'b0;
   logic [31:0] hrdata;
   logic        hreadyout, hresp, term, e0, e1, fwd, fs;
   wire         lt, ll, at, al, ft;
   int          fails = 0, checks_done = 0, n0 = 0, n1 = 0, nf = 0, c;
   always #5 hclk = ~hclk;
   always @(posedge hclk) begin
      if (e0 === 1'b1) n0++;
      if (e1 === 1'b1) n1++;
      if (fs === 1'b1) nf++;
   end
   tdlt_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .line_ttl_in(lt), .line_lvds_in(ll), .aux_ttl_in(at), .aux_lvds_in(al),
      .frame_ttl_in(ft), .lvds_term_en(term), .expose_line0(e0),
      .expose_line1(e1), .shift_fwd(fwd), .frame_start(fs));
   tdlt_enc_model m (.hclk(hclk), .term(term), .quad(quad_m), .line_ttl_in(lt),
      .line_lvds_in(ll), .aux_ttl_in(at), .aux_lvds_in(al), .frame_ttl_in(ft));
   task automatic final_report;
      if (fails == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 100);
      if (n >= 100) begin
         fails++;
         final_report();
      end
   endtask : wait_rdy
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      hsel   <= 1'b1;
      hsize  <= 3'h2;
      htrans <= 2'h2;
      haddr  <= a;
      hwrite <= w;
      wait_rdy();
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(nm, q, exp);
   endtask : rd
   task automatic t_regs;
      rd("ctrl", `TDLT_ADDR_CTRL, `TDLT_CTRL_RESET);
      rd("divisor", `TDLT_ADDR_DIVISOR, 32'h0000_0001);
      rd("shutter", `TDLT_ADDR_SHUTTER, 32'h0000_03E8);
      rd("unmapped", 12'h020, 32'h0000_0000);
      chk("hresp", {31'h0, hresp}, 32'h0);
      wr(`TDLT_ADDR_DIVISOR, 32'h0);
      rd("div_zero", `TDLT_ADDR_DIVISOR, 32'h0000_0001);
      wr(`TDLT_ADDR_CTRL, 32'h4);
      // the termination output is registered one cycle after the write
      repeat (2) @(posedge hclk);
      chk("term", {31'h0, term}, 32'h1);
      // receiver switch glitches the line, so it is undone while still offline
      wr(`TDLT_ADDR_CTRL, 32'h0);
      repeat (2) @(posedge hclk);
      chk("term_off", {31'h0, term}, 32'h0);
   endtask : t_regs
   task automatic t_single;
      wr(`TDLT_ADDR_SHUTTER, 32'h8);
      wr(`TDLT_ADDR_DIVISOR, 32'h100);
      // the internal trigger after reset runs a full default-length exposure
      repeat (1010) @(posedge hclk);
      wr(`TDLT_ADDR_CTRL, 32'h1);
      m.set_dir(1'b1);
      c = n0;
      m.pulse(12);
      chk("fwd_hi", {31'h0, fwd}, 32'h1);
      chk("line0", n0 - c, 32'h1);
      m.set_dir(1'b0);
      c = n1;
      // second edge lands inside the running exposure
      m.pulse(1);
      m.pulse(12);
      chk("fwd_lo", {31'h0, fwd}, 32'h0);
      chk("line1_early", n1 - c, 32'h1);
   endtask : t_single
   task automatic t_quad;
      quad_m <= 1'b1;
      wr(`TDLT_ADDR_CTRL, 32'h7);
      // let the receiver switch settle before the first encoder step
      repeat (6) @(posedge hclk);
      c = n0;
      repeat (3) m.step(1'b1, 1'b0);
      chk("q_fwd", {31'h0, fwd}, 32'h1);
      chk("q_line0", n0 - c, 32'h3);
      c = n1;
      repeat (3) m.step(1'b0, 1'b0);
      chk("q_rev", {31'h0, fwd}, 32'h0);
      chk("q_line1", n1 - c, 32'h3);
      c = n0 + n1;
      m.step(1'b0, 1'b1);
      chk("q_both", n0 + n1 - c, 32'h0);
   endtask : t_quad
   task automatic t_div;
      quad_m <= 1'b0;
      wr(`TDLT_ADDR_CTRL, 32'h1);
      wr(`TDLT_ADDR_DIVISOR, 32'h200);
      m.set_dir(1'b1);
      c = n0;
      repeat (4) m.pulse(12);
      chk("div512", n0 - c, 32'h2);
   endtask : t_div
   task automatic t_offline;
      wr(`TDLT_ADDR_CTRL, 32'h0);
      repeat (20) @(posedge hclk);
      // sample between edges so the pulse counter has settled
      @(negedge hclk);
      c = n0 + n1;
      repeat (45) @(negedge hclk);
      chk("offline", n0 + n1 - c, 32'h5);
   endtask : t_offline
   task automatic t_frame;
      @(posedge hclk);
      wr(`TDLT_ADDR_CTRL, 32'h5);
      c = nf;
      m.frame_pulse();
      chk("frame", nf - c, 32'h1);
   endtask : t_frame
   initial begin
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_regs();
      t_single();
      t_quad();
      t_div();
      t_offline();
      t_frame();
      final_report();
   end
endmodule : tdi_line_trigger_direction_tb_top
`default_nettype wire
